// File: design/comparator_cfg.svh
`ifndef COMPARATOR_CFG_SVH
`define COMPARATOR_CFG_SVH
// register offsets
`define CMP_OFS_INPUT_DISABLE 8'h17
`define CMP_OFS_CONTROL_STATUS 8'h1f
`define CMP_OFS_IO_CONTROL 8'h20
// control/status field positions
`define CMP_BIT_POWER_OFF 7
`define CMP_BIT_BANDGAP 6
`define CMP_BIT_RESULT 5
`define CMP_BIT_FLAG 4
`define CMP_BIT_IRQ_EN 3
`define CMP_BIT_CAPTURE 2
`define CMP_BIT_MODE_HI 1
`define CMP_BIT_MODE_LO 0
// io control field positions
`define CMP_BIT_PIN_EN 1
`define CMP_BIT_POS_SEL 0
// reset values
`define CMP_RST_BYTE 8'h00
`endif

// File: design/comparator_pkg.sv
package comparator_pkg;
  typedef enum logic [1:0] {
    MODE_TOGGLE = 2'h0,
    MODE_RESERVED = 2'h1,
    MODE_FALL = 2'h2,
    MODE_RISE = 2'h3
  } event_mode_e;
endpackage

// File: design/cmp_event_if.sv
`timescale 1ns/1ps
// carries the synchronised result and the chosen mode to the detector
interface cmp_event_if;
  logic level;
  comparator_pkg::event_mode_e mode;
  logic hit;
  modport ctrl (output level, output mode, input hit);
  modport det (input level, input mode, output hit);
endinterface

// File: design/cmp_event_detect.sv
`timescale 1ns/1ps
// compares the synchronised result with its previous value
module cmp_event_detect (
  input wire logic clk_in, // system clock
  input wire logic arst_n_in, // async reset, active low
  cmp_event_if.det ev // level in, hit out
);
  typedef struct packed {
    logic prev;
  } det_state_s;
  det_state_s state;
  det_state_s next_state;
  logic rise;
  logic fall;

  // ==========================================
  // edge detection
  // one-cycle history comparison
  always_comb begin
    next_state = state;
    next_state.prev = ev.level;
    rise = ev.level & ~state.prev;
    fall = ~ev.level & state.prev;
    unique case (ev.mode)
      comparator_pkg::MODE_TOGGLE: ev.hit = rise | fall;
      comparator_pkg::MODE_RESERVED: ev.hit = 1'b0; // reserved never fires
      comparator_pkg::MODE_FALL: ev.hit = fall;
      comparator_pkg::MODE_RISE: ev.hit = rise;
    endcase
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  chk_reserved_quiet: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    ev.mode == comparator_pkg::MODE_RESERVED |-> !ev.hit)
    else $error("reserved mode raised an event");
  // rising mode fires only on rise
  chk_rise_mode: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (ev.mode == comparator_pkg::MODE_RISE && ev.hit) |-> (ev.level && !$past(ev.level)))
    else $error("rise event without rising edge");
endmodule

// File: design/comparator_control.sv
`timescale 1ns/1ps
`include "comparator_cfg.svh"
// ==========================================
// Behaviour
// - raw result high when positive exceeds negative
// - power-off bit switches comparator off
// - bandgap bit enables internal reference
// - select bit picks bandgap or pin
// - result bit synchronised, one-two cycles late
// - matching event sets the flag
// - vector or written one clears flag
// - irq needs flag, enable, global enable
// - mode field selects toggle, fall, rise
// - capture bit routes result to timer
// - pin enable drives result out
// - disable bits force port inputs zero
// - only bits one and zero reach comparator
module comparator_control #(
  parameter int PIN_COUNT = 8 // analog pins with input buffers
) (
  input wire logic clk_in, // system clock 200 MHz
  input wire logic arst_n_in, // async reset, active low
  input wire logic [7:0] addr_in, // register address
  input wire logic [7:0] wdata_in, // write data
  input wire logic wr_in, // write strobe
  input wire logic rd_in, // read strobe
  output logic [7:0] rdata_out, // read data, cycle after strobe
  input wire logic analog_result_in, // raw result from analog core
  output logic comparator_power_off_out, // power down analog core
  output logic bandgap_enable_out, // reference enable
  output logic positive_input_select_out, // 1 bandgap, 0 pin
  input wire logic global_irq_enable_in, // processor global enable
  input wire logic irq_ack_in, // vector being executed
  output logic irq_out, // comparator interrupt request
  output logic capture_out, // result to timer capture front end
  output logic result_pin_out, // dedicated output pin level
  output logic result_pin_oe_out, // dedicated output pin enable
  input wire logic [PIN_COUNT-1:0] pin_digital_in, // buffered pin levels
  output logic [PIN_COUNT-1:0] pin_buffer_off_out, // buffer disables
  output logic [PIN_COUNT-1:0] port_read_out // port input bits
);
  // elaboration check: the disable register is eight bits wide and bits 1:0 are the comparator pins
  if (PIN_COUNT < 2 || PIN_COUNT > 8) begin
    $error("PIN_COUNT must be 2..8");
  end

  typedef struct packed {
    logic [7:0] input_disable;
    logic power_off;
    logic bandgap;
    logic flag;
    logic irq_en;
    logic capture;
    logic [1:0] mode;
    logic pin_en;
    logic pos_sel;
    logic sync1;
    logic sync2;
    logic [PIN_COUNT-1:0] pin_s1;
    logic [PIN_COUNT-1:0] pin_s2;
    logic [7:0] rdata;
  } ctl_state_s;
  ctl_state_s state;
  ctl_state_s next_state;

  cmp_event_if ev_if ();

  // ==========================================
  // event detector
  assign ev_if.level = state.sync2;
  assign ev_if.mode = comparator_pkg::event_mode_e'(state.mode);

  cmp_event_detect u_detect (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .ev(ev_if.det)
  );

  // assembles the status byte; result bit is live, never stored by writes
  function automatic logic [7:0] status_byte(input ctl_state_s s);
    logic [7:0] b;
    b = 8'h00;
    b[`CMP_BIT_POWER_OFF] = s.power_off;
    b[`CMP_BIT_BANDGAP] = s.bandgap;
    b[`CMP_BIT_RESULT] = s.sync2;
    b[`CMP_BIT_FLAG] = s.flag;
    b[`CMP_BIT_IRQ_EN] = s.irq_en;
    b[`CMP_BIT_CAPTURE] = s.capture;
    b[`CMP_BIT_MODE_HI] = s.mode[1];
    b[`CMP_BIT_MODE_LO] = s.mode[0];
    return b;
  endfunction

  // ==========================================
  // next-state logic
  always_comb begin
    next_state = state;
    // raw result enters through two flops, it is asynchronous
    // second stage is the readable result
    next_state.sync1 = analog_result_in;
    next_state.sync2 = state.sync1;
    next_state.pin_s1 = pin_digital_in;
    next_state.pin_s2 = state.pin_s1;
    // register writes
    if (wr_in) begin
      if (addr_in == `CMP_OFS_CONTROL_STATUS) begin
        next_state.power_off = wdata_in[`CMP_BIT_POWER_OFF];
        next_state.bandgap = wdata_in[`CMP_BIT_BANDGAP];
        next_state.irq_en = wdata_in[`CMP_BIT_IRQ_EN];
        next_state.capture = wdata_in[`CMP_BIT_CAPTURE];
        next_state.mode = {wdata_in[`CMP_BIT_MODE_HI], wdata_in[`CMP_BIT_MODE_LO]};
        if (wdata_in[`CMP_BIT_FLAG]) begin
          next_state.flag = 1'b0;
        end
      end else if (addr_in == `CMP_OFS_IO_CONTROL) begin
        next_state.pin_en = wdata_in[`CMP_BIT_PIN_EN];
        next_state.pos_sel = wdata_in[`CMP_BIT_POS_SEL];
      end else if (addr_in == `CMP_OFS_INPUT_DISABLE) begin
        next_state.input_disable = wdata_in;
      end
    end
    if (irq_ack_in) begin
      next_state.flag = 1'b0;
    end
    if (ev_if.hit) begin
      next_state.flag = 1'b1;
    end
    // reads answer one cycle later; unmapped reads zero
    next_state.rdata = 8'h00;
    if (rd_in) begin
      unique case (addr_in)
        `CMP_OFS_CONTROL_STATUS: next_state.rdata = status_byte(state);
        `CMP_OFS_IO_CONTROL: begin
          next_state.rdata[`CMP_BIT_PIN_EN] = state.pin_en;
          next_state.rdata[`CMP_BIT_POS_SEL] = state.pos_sel;
        end
        `CMP_OFS_INPUT_DISABLE: next_state.rdata = state.input_disable;
        default: next_state.rdata = 8'h00;
      endcase
    end
  end

  // ==========================================
  // state register
  // every field resets to zero
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================
  // outputs
  assign rdata_out = state.rdata;
  assign comparator_power_off_out = state.power_off;
  assign bandgap_enable_out = state.bandgap;
  assign positive_input_select_out = state.pos_sel;
  assign irq_out = state.flag & state.irq_en & global_irq_enable_in;
  // capture sees nothing when routing is off
  assign capture_out = state.capture & state.sync2;
  assign result_pin_out = state.pin_en & state.sync2;
  assign result_pin_oe_out = state.pin_en;
  // bits 1:0 cover the comparator pins, each bit below PIN_COUNT gates its own pin
  assign pin_buffer_off_out = state.input_disable[PIN_COUNT-1:0];
  assign port_read_out = state.pin_s2 & ~state.input_disable[PIN_COUNT-1:0];

  // ==========================================
  // checks
  // request needs all three
  chk_irq_gate: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    irq_out |-> (state.flag && state.irq_en && global_irq_enable_in))
    else $error("interrupt without flag and enables");

  // two-flop latency, skipped while the flops still hold reset values
  chk_result_sync: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    ($past(arst_n_in) && $past(arst_n_in, 2)) |-> state.sync2 == $past(analog_result_in, 2))
    else $error("result bit latency wrong");

  chk_flag_set: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    ev_if.hit |=> state.flag)
    else $error("event did not set flag");

  chk_flag_ack: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (irq_ack_in && !ev_if.hit) |=> !state.flag)
    else $error("vector did not clear flag");

  chk_flag_w1c: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (wr_in && addr_in == `CMP_OFS_CONTROL_STATUS && wdata_in[`CMP_BIT_FLAG] && !ev_if.hit) |=> !state.flag)
    else $error("write one did not clear flag");

  chk_flag_hold: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (!state.flag && !ev_if.hit) |=> !state.flag)
    else $error("flag set without event");

  chk_power_write: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (wr_in && addr_in == `CMP_OFS_CONTROL_STATUS) |=>
      comparator_power_off_out == $past(wdata_in[`CMP_BIT_POWER_OFF]))
    else $error("power-off bit not written");

  chk_port_zero: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (port_read_out & state.input_disable[PIN_COUNT-1:0]) == '0)
    else $error("disabled pin reads non-zero");

  chk_pin_drive: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    !result_pin_oe_out |-> !result_pin_out)
    else $error("pin driven while disabled");

  chk_capture_off: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    !state.capture |-> !capture_out)
    else $error("capture fed while routing off");

  chk_read_answer: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (rd_in && addr_in == `CMP_OFS_INPUT_DISABLE) |=> rdata_out == $past(state.input_disable))
    else $error("read data wrong");

  // ==========================================
  // register map checks
  // status byte layout
  chk_status_read: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (rd_in && addr_in == `CMP_OFS_CONTROL_STATUS) |=>
      rdata_out == {$past(state.power_off), $past(state.bandgap), $past(state.sync2), $past(state.flag),
      $past(state.irq_en), $past(state.capture), $past(state.mode)})
    else $error("status byte layout wrong");

  chk_read_idle: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    !rd_in |=> rdata_out == 8'h00)
    else $error("read data outside its cycle");

  chk_io_read: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (rd_in && addr_in == `CMP_OFS_IO_CONTROL) |=> rdata_out == {6'h00, $past(state.pin_en), $past(state.pos_sel)})
    else $error("io control read wrong");

  chk_unmapped_read: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (rd_in && addr_in != `CMP_OFS_CONTROL_STATUS && addr_in != `CMP_OFS_IO_CONTROL
      && addr_in != `CMP_OFS_INPUT_DISABLE) |=> rdata_out == 8'h00)
    else $error("unmapped read not zero");

  chk_bandgap_write: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (wr_in && addr_in == `CMP_OFS_CONTROL_STATUS) |=> bandgap_enable_out == $past(wdata_in[`CMP_BIT_BANDGAP]))
    else $error("bandgap bit not written");

  chk_select_write: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (wr_in && addr_in == `CMP_OFS_IO_CONTROL) |=> positive_input_select_out == $past(wdata_in[`CMP_BIT_POS_SEL]))
    else $error("select bit not written");

  chk_pin_en_write: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (wr_in && addr_in == `CMP_OFS_IO_CONTROL) |=> result_pin_oe_out == $past(wdata_in[`CMP_BIT_PIN_EN]))
    else $error("pin enable not written");

  chk_mode_write: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (wr_in && addr_in == `CMP_OFS_CONTROL_STATUS) |=>
      state.mode == {$past(wdata_in[`CMP_BIT_MODE_HI]), $past(wdata_in[`CMP_BIT_MODE_LO])})
    else $error("mode field not written");

  chk_irqen_write: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (wr_in && addr_in == `CMP_OFS_CONTROL_STATUS) |=> state.irq_en == $past(wdata_in[`CMP_BIT_IRQ_EN]))
    else $error("irq enable not written");

  chk_capture_write: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (wr_in && addr_in == `CMP_OFS_CONTROL_STATUS) |=> state.capture == $past(wdata_in[`CMP_BIT_CAPTURE]))
    else $error("capture bit not written");

  chk_disable_write: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (wr_in && addr_in == `CMP_OFS_INPUT_DISABLE) |=> pin_buffer_off_out == $past(wdata_in[PIN_COUNT-1:0]))
    else $error("disable bits not written");

  chk_power_hold: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    !wr_in |=> $stable(comparator_power_off_out))
    else $error("power-off changed without a write");

  // ==========================================
  // result path and event checks
  // pin follows result
  chk_pin_follow: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    result_pin_oe_out |-> result_pin_out == state.sync2)
    else $error("pin does not follow result");

  chk_capture_follow: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    state.capture |-> capture_out == state.sync2)
    else $error("capture does not follow result");

  chk_irq_global: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    !global_irq_enable_in |-> !irq_out)
    else $error("request with global enable off");

  chk_flag_keep: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (state.flag && !irq_ack_in && !(wr_in && addr_in == `CMP_OFS_CONTROL_STATUS && wdata_in[`CMP_BIT_FLAG]))
      |=> state.flag)
    else $error("flag lost without a clear");

  chk_toggle_fire: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (state.mode == 2'h0 && state.sync2 != $past(state.sync2)) |=> state.flag)
    else $error("toggle missed");

  chk_fall_fire: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (state.mode == 2'h2 && !state.sync2 && $past(state.sync2)) |=> state.flag)
    else $error("falling edge missed");

  chk_rise_fire: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (state.mode == 2'h3 && state.sync2 && !$past(state.sync2)) |=> state.flag)
    else $error("rising edge missed");

  // pin levels two flops late, skipped while the flops still hold reset values
  chk_pin_sync: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    ($past(arst_n_in) && $past(arst_n_in, 2)) |-> state.pin_s2 == $past(pin_digital_in, 2))
    else $error("pin level latency wrong");
endmodule

// File: testbench/analog_core_model.sv
`timescale 1ns/1ps
// ==========================================
// analog core stand-in, input levels in millivolts
module analog_core_model #(
  parameter int BANDGAP_MV = 1100 // internal reference level
) (
  input wire integer pos_pin_mv_in, // positive pin level
  input wire integer neg_pin_mv_in, // negative pin level
  input wire logic power_off_in, // core switched off
  input wire logic bandgap_enable_in, // reference on
  input wire logic select_in, // 1 reference, 0 pin
  output logic result_out // raw result
);
  int pos_mv;
  // an unpowered reference reads 0 mV, so selecting it too early gives a wrong result
  assign pos_mv = select_in ? (bandgap_enable_in ? BANDGAP_MV : 0) : pos_pin_mv_in;
  assign result_out = !power_off_in && (pos_mv > neg_pin_mv_in);
endmodule

// File: testbench/comparator_control_irq_tb.sv
`timescale 1ns/1ps
// ==========================================
// bench for the comparator control block
module comparator_control_irq_tb;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic glob = 1'b1;
  logic ack = 1'b0;
  logic [7:0] pins = 8'ha5;
  int pos_mv = 100;
  int neg_mv = 500;
  logic [7:0] rdata, boff, pread;
  logic res, poff, bg, sel, irq, cap, rpin, roe;
  int n_fail = 0;
  int comparisons = 0;
  // half period of 2.5 ns gives 200 MHz
  always #2.5 clk_in = ~clk_in;
  comparator_control dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr_s), .rd_in(rd_s), .rdata_out(rdata), .analog_result_in(res), .comparator_power_off_out(poff),
    .bandgap_enable_out(bg), .positive_input_select_out(sel), .global_irq_enable_in(glob),
    .irq_ack_in(ack), .irq_out(irq), .capture_out(cap), .result_pin_out(rpin), .result_pin_oe_out(roe),
    .pin_digital_in(pins), .pin_buffer_off_out(boff), .port_read_out(pread));
  analog_core_model core (.pos_pin_mv_in(pos_mv), .neg_pin_mv_in(neg_mv), .power_off_in(poff),
    .bandgap_enable_in(bg), .select_in(sel), .result_out(res));
  // ==========================================
  // shared tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk_in);
    wr_s <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_in);
    rd_s <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  // move the positive pin, then let synchroniser and flag settle
  task automatic drive_pos(input int mv);
    @(posedge clk_in);
    pos_mv <= mv;
    repeat (4) @(posedge clk_in);
    #1;
  endtask
  task automatic stop_test;
    if (n_fail == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset;
    #1;
    chk({irq, poff, bg, sel, cap, rpin, roe, 1'b0}, 8'h00);
    rd_chk(8'h1f, 8'h00);
    rd_chk(8'h17, 8'h00);
    rd_chk(8'h20, 8'h00);
    rd_chk(8'h30, 8'h00);
  endtask
  task automatic t_control;
    wr(8'h1f, 8'hf7); // power and mode move with irq enable clear
    rd_chk(8'h1f, 8'hc7);
    chk({poff, bg}, 8'h03);
    wr(8'h1f, 8'h00);
  endtask
  task automatic t_route;
    wr(8'h1f, 8'h44); // reference on first
    wr(8'h20, 8'h03); // then selected
    drive_pos(100);
    // the capture interrupt enable lives in the timer, beyond this block
    chk({roe, rpin, cap, sel}, 8'h0f);
    rd_chk(8'h1f, 8'h74);
    wr(8'h20, 8'h00);
    wr(8'h1f, 8'h00);
    drive_pos(100);
    wr(8'h1f, 8'h10);
    chk({roe, rpin, cap, sel}, 8'h00);
    rd_chk(8'h1f, 8'h00);
  endtask
  task automatic t_modes;
    logic [7:0] m, e;
    m = 8'h00;
    for (int i = 0; i < 4; i++) begin
      // irq enable drops under the old mode first, then the mode moves
      wr(8'h1f, 8'h10 | m);
      m = i[7:0];
      wr(8'h1f, 8'h10 | m);
      wr(8'h1f, 8'h18 | m);
      e = (i == 0 || i == 3) ? 8'h10 : 8'h00;
      drive_pos(900);
      chk({7'h00, irq}, e >> 4);
      rd_chk(8'h1f, 8'h28 | m | e);
      wr(8'h1f, 8'h08 | m);
      rd_chk(8'h1f, 8'h28 | m | e);
      wr(8'h1f, 8'h18 | m);
      rd_chk(8'h1f, 8'h28 | m);
      e = (i == 0 || i == 2) ? 8'h10 : 8'h00;
      drive_pos(100);
      rd_chk(8'h1f, 8'h08 | m | e);
      @(posedge clk_in);
      ack <= 1'b1;
      @(posedge clk_in);
      ack <= 1'b0;
      #1;
      chk({7'h00, irq}, 8'h00);
      rd_chk(8'h1f, 8'h08 | m);
    end
  endtask
  task automatic t_global;
    @(posedge clk_in);
    glob <= 1'b0;
    drive_pos(900);
    chk({7'h00, irq}, 8'h00);
    @(posedge clk_in);
    glob <= 1'b1;
    #1;
    chk({7'h00, irq}, 8'h01);
    wr(8'h1f, 8'h13);
    drive_pos(100);
    rd_chk(8'h1f, 8'h03);
  endtask
  task automatic t_pins;
    chk(pread, 8'ha5);
    wr(8'h17, 8'h03);
    repeat (3) @(posedge clk_in);
    #1;
    chk(pread, 8'ha4);
    chk(boff, 8'h03);
    rd_chk(8'h17, 8'h03);
    @(posedge clk_in);
    pins <= 8'h5a;
    repeat (3) @(posedge clk_in);
    #1;
    chk(pread, 8'h58);
  endtask
  // reset in mid-run clears every field
  task automatic t_midreset;
    wr(8'h1f, 8'h44);
    wr(8'h20, 8'h02);
    @(posedge clk_in);
    arst_n_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    arst_n_in <= 1'b1;
    #1;
    chk({4'h0, poff, bg, cap, roe}, 8'h00);
    chk(boff, 8'h00);
    rd_chk(8'h1f, 8'h00);
    rd_chk(8'h20, 8'h00);
    rd_chk(8'h17, 8'h00);
  endtask
  // ==========================================
  // main sequence: reset for 3 cycles, then scenarios
  initial begin
    repeat (3) @(posedge clk_in);
    arst_n_in <= 1'b1;
    t_reset();
    t_control();
    t_route();
    t_modes();
    t_global();
    t_pins();
    t_midreset();
    stop_test();
  end
  // watchdog so a hang ends in the report
  initial begin
    repeat (20000) @(posedge clk_in);
    n_fail++;
    stop_test();
  end
endmodule
